// ### ies_core.sv
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module ies_core #(
	parameter int PRESC_W = 7,
	parameter int DEPTH_W = 3
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// write address and data
	input  wire logic [4:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	// write response
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	// read
	input  wire logic [4:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	// power state
	output logic             OSC_RUN,
	output logic             SLEEPING
);
	ies_pkg::ies_state_e state_q;
	logic [7:0]  fmem [128];
	logic [12:0] stack_mem [2**DEPTH_W];
	logic [DEPTH_W-1:0] sp_q;
	logic [12:0] pc_q;
	logic [7:0]  acc_q;
	logic [6:0]  fadr_q;
	logic        c_q, dc_q, z_q, to_q, pd_q;
	logic [PRESC_W-1:0] presc_q;
	logic [7:0]  wdt_q;
	logic        ex_go_q, ex_dst_q;
	logic [3:0]  ex_op_q;
	logic [6:0]  ex_f_q;
	logic [7:0]  ex_k_q;
	logic [4:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic        aw_full_q, w_full_q;
	logic        wr_take, wr_ok, ins_ok, wake_ok, busy, exec, wdt_ovf;
	logic [7:0]  alu_res;
	logic        alu_c, alu_dc, alu_z, wr_c, wr_dc, wr_z, dest_op;
	logic [12:0] stack_head;
	logic [31:0] rd_word;
	logic        rd_hit;

	ies_alu u_alu (
		.op     (ex_op_q),
		.acc    (acc_q),
		.freg   (fmem[ex_f_q]),
		.lit    (ex_k_q),
		.c_in   (c_q),
		.res    (alu_res),
		.c_out  (alu_c),
		.dc_out (alu_dc),
		.z_out  (alu_z),
		.wr_c   (wr_c),
		.wr_dc  (wr_dc),
		.wr_z   (wr_z)
	);

	assign exec = ex_go_q;
	assign busy = ex_go_q | (state_q == ies_pkg::IES_RET);
	assign stack_head = stack_mem[sp_q - 1'b1];
	assign dest_op = (ex_op_q == ies_pkg::OP_RRF) | (ex_op_q == ies_pkg::OP_REG_MINUS_ACC) |
		(ex_op_q == ies_pkg::OP_NIBBLE_EXCHANGE) | (ex_op_q == ies_pkg::OP_XOR_ACC_REG);
	assign wdt_ovf = (&presc_q) & (&wdt_q);

	// one write completes only when both halves are held and no response is pending
	assign wr_take = aw_full_q & w_full_q & ~S_AXI_BVALID;
	assign ins_ok = (state_q == ies_pkg::IES_RUN) & ~busy & ~w_data_q[ies_pkg::CTRL_WAKE_BIT];
	assign wake_ok = (state_q == ies_pkg::IES_SLEEP) & w_data_q[ies_pkg::CTRL_WAKE_BIT];
	always_comb begin
		case (aw_addr_q)
			ies_pkg::OFF_CTRL: wr_ok = ins_ok | wake_ok;
			ies_pkg::OFF_ACC, ies_pkg::OFF_STAT, ies_pkg::OFF_FADR: wr_ok = ~busy;
			ies_pkg::OFF_FDAT, ies_pkg::OFF_PUSH: wr_ok = ~busy;
			default: wr_ok = 1'b0;
		endcase
	end

	// write channels, taken in either order
	always_ff @(posedge CLK) begin
		if (RST) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= ies_pkg::RESP_OK;
			aw_addr_q <= 5'h00;
			w_data_q <= 32'h00000000;
		end else begin
			if (S_AXI_AWVALID & S_AXI_AWREADY) begin
				aw_full_q <= 1'b1;
				S_AXI_AWREADY <= 1'b0;
				aw_addr_q <= {S_AXI_AWADDR[4:2], 2'b00};
			end
			if (S_AXI_WVALID & S_AXI_WREADY) begin
				w_full_q <= 1'b1;
				S_AXI_WREADY <= 1'b0;
				w_data_q <= S_AXI_WDATA;
			end
			if (wr_take) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY <= 1'b1;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_ok ? ies_pkg::RESP_OK : ies_pkg::RESP_ERR;
			end else if (S_AXI_BVALID & S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// instruction latch; executes on the following edge
	always_ff @(posedge CLK) begin
		if (RST) begin
			ex_go_q <= 1'b0;
			ex_op_q <= ies_pkg::OP_NOP;
			ex_dst_q <= ies_pkg::DEST_ACC;
			ex_f_q <= 7'h00;
			ex_k_q <= 8'h00;
		end else begin
			ex_go_q <= wr_take & (aw_addr_q == ies_pkg::OFF_CTRL) & ins_ok;
			if (wr_take & (aw_addr_q == ies_pkg::OFF_CTRL) & ins_ok) begin
				ex_op_q <= w_data_q[ies_pkg::CTRL_OP_LSB +: 4];
				ex_dst_q <= w_data_q[ies_pkg::CTRL_DST_BIT];
				ex_f_q <= w_data_q[ies_pkg::CTRL_F_LSB +: 7];
				ex_k_q <= w_data_q[ies_pkg::CTRL_K_LSB +: 8];
			end
		end
	end

	// power state; the watchdog is cleared on entering sleep, then keeps counting through it
	always_ff @(posedge CLK) begin
		if (RST) begin
			state_q <= ies_pkg::IES_RUN;
			OSC_RUN <= 1'b1;
			SLEEPING <= 1'b0;
		end else begin
			case (state_q)
				ies_pkg::IES_RUN: begin
					if (exec & (ex_op_q == ies_pkg::OP_SLEEP)) begin
						state_q <= ies_pkg::IES_SLEEP;
						OSC_RUN <= 1'b0;
						SLEEPING <= 1'b1;
					end else if (exec & (ex_op_q == ies_pkg::OP_RETURN)) begin
						state_q <= ies_pkg::IES_RET;
					end
				end
				ies_pkg::IES_RET: state_q <= ies_pkg::IES_RUN;
				ies_pkg::IES_SLEEP: begin
					if (wdt_ovf | (wr_take & (aw_addr_q == ies_pkg::OFF_CTRL) & wake_ok)) begin
						state_q <= ies_pkg::IES_RUN;
						OSC_RUN <= 1'b1;
						SLEEPING <= 1'b0;
					end
				end
				default: state_q <= ies_pkg::IES_RUN;
			endcase
		end
	end

	// watchdog counter and its prescaler
	always_ff @(posedge CLK) begin
		if (RST) begin
			presc_q <= '0;
			wdt_q <= ies_pkg::WDT_CLR;
		end else if (exec & (ex_op_q == ies_pkg::OP_SLEEP)) begin
			presc_q <= '0;
			wdt_q <= ies_pkg::WDT_CLR;
		end else begin
			presc_q <= presc_q + 1'b1;
			if (&presc_q) begin
				wdt_q <= wdt_q + 8'h01;
			end
		end
	end

	// status flags; bus writes lose to the instruction by branch order, though the two cannot coincide
	always_ff @(posedge CLK) begin
		if (RST) begin
			c_q <= 1'b0;
			dc_q <= 1'b0;
			z_q <= 1'b0;
			to_q <= ies_pkg::TO_RST;
			pd_q <= ies_pkg::PD_RST;
		end else begin
			if (exec & (ex_op_q == ies_pkg::OP_SLEEP)) begin
				to_q <= 1'b1;
				pd_q <= 1'b0;
			end else if (wdt_ovf) begin
				to_q <= 1'b0;
			end
			if (exec) begin
				if (wr_c) c_q <= alu_c;
				if (wr_dc) dc_q <= alu_dc;
				if (wr_z) z_q <= alu_z;
			end else if (wr_take & wr_ok & (aw_addr_q == ies_pkg::OFF_STAT)) begin
				c_q <= w_data_q[ies_pkg::SB_C];
				dc_q <= w_data_q[ies_pkg::SB_DC];
				z_q <= w_data_q[ies_pkg::SB_Z];
			end
		end
	end

	// accumulator and file address
	always_ff @(posedge CLK) begin
		if (RST) begin
			acc_q <= ies_pkg::ACC_RST;
			fadr_q <= 7'h00;
		end else begin
			if (exec & ((dest_op & (ex_dst_q == ies_pkg::DEST_ACC)) |
				(ex_op_q == ies_pkg::OP_LITERAL_MINUS_ACC) | (ex_op_q == ies_pkg::OP_XOR_ACC_LITERAL))) begin
				acc_q <= alu_res;
			end else if (wr_take & wr_ok & (aw_addr_q == ies_pkg::OFF_ACC)) begin
				acc_q <= w_data_q[7:0];
			end
			if (wr_take & wr_ok & (aw_addr_q == ies_pkg::OFF_FADR)) begin
				fadr_q <= w_data_q[6:0];
			end
		end
	end

	// file registers; contents are not reset
	always_ff @(posedge CLK) begin
		if (exec & dest_op & (ex_dst_q == ies_pkg::DEST_FILE)) begin
			fmem[ex_f_q] <= alu_res;
		end else if (wr_take & wr_ok & (aw_addr_q == ies_pkg::OFF_FDAT)) begin
			fmem[fadr_q] <= w_data_q[7:0];
		end
	end

	// circular stack, as in the core: overflow silently wraps
	always_ff @(posedge CLK) begin
		if (RST) begin
			sp_q <= '0;
			pc_q <= ies_pkg::PC_RST;
		end else if (exec & (ex_op_q == ies_pkg::OP_RETURN)) begin
			sp_q <= sp_q - 1'b1;
			pc_q <= stack_head;
		end else begin
			if (exec) begin
				pc_q <= pc_q + 13'h0001;
			end
			if (wr_take & wr_ok & (aw_addr_q == ies_pkg::OFF_PUSH)) begin
				stack_mem[sp_q] <= w_data_q[12:0];
				sp_q <= sp_q + 1'b1;
			end
		end
	end

	// read channel, one cycle after the address is taken
	always_comb begin
		rd_hit = 1'b1;
		rd_word = 32'h00000000;
		case ({S_AXI_ARADDR[4:2], 2'b00})
			ies_pkg::OFF_CTRL: rd_word = {24'h000000, ex_k_q};
			ies_pkg::OFF_ACC: rd_word = {24'h000000, acc_q};
			ies_pkg::OFF_STAT: rd_word = {25'h0000000, busy, SLEEPING, to_q, pd_q, z_q, dc_q, c_q};
			ies_pkg::OFF_FADR: rd_word = {25'h0000000, fadr_q};
			ies_pkg::OFF_FDAT: rd_word = {24'h000000, fmem[fadr_q]};
			ies_pkg::OFF_PC: rd_word = {19'h00000, pc_q};
			ies_pkg::OFF_PUSH: rd_word = {{(32 - DEPTH_W){1'b0}}, sp_q};
			ies_pkg::OFF_WDT: rd_word = {24'h000000, wdt_q};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= ies_pkg::RESP_OK;
		end else if (S_AXI_ARVALID & S_AXI_ARREADY) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rd_word;
			S_AXI_RRESP <= rd_hit ? ies_pkg::RESP_OK : ies_pkg::RESP_ERR;
		end else if (S_AXI_RVALID & S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_ARREADY <= 1'b1;
		end
	end

	sequence s_exec(logic [3:0] op);
		exec && (ex_op_q == op);
	endsequence
	sequence s_ret_done;
		busy ##1 !busy;
	endsequence

	chk_sleep_flags: assert property (@(posedge CLK) disable iff (RST)
		s_exec(ies_pkg::OP_SLEEP) |=> to_q && !pd_q && wdt_q == 8'h00 && presc_q == '0)
		else $error("power-down did not clear watchdog or set flags");
	chk_sleep_osc: assert property (@(posedge CLK) disable iff (RST)
		s_exec(ies_pkg::OP_SLEEP) |=> !OSC_RUN && SLEEPING)
		else $error("oscillator still running after power-down");
	chk_ret_two: assert property (@(posedge CLK) disable iff (RST)
		s_exec(ies_pkg::OP_RETURN) |=> (pc_q == $past(stack_head)) && $stable({c_q, dc_q, z_q})
		##0 s_ret_done)
		else $error("return did not load head or take two cycles");
	chk_rrf_carry: assert property (@(posedge CLK) disable iff (RST)
		s_exec(ies_pkg::OP_RRF) |-> alu_res == {c_q, fmem[ex_f_q][7:1]}
		##1 (c_q == $past(fmem[ex_f_q][0]) && $stable({dc_q, z_q})))
		else $error("rotation carry wrong or other flag moved");
	chk_dest_acc: assert property (@(posedge CLK) disable iff (RST)
		exec && dest_op && ex_dst_q == ies_pkg::DEST_ACC |=> acc_q == $past(alu_res))
		else $error("result not routed to accumulator");
	chk_literal_minus_acc_acc: assert property (@(posedge CLK) disable iff (RST)
		s_exec(ies_pkg::OP_LITERAL_MINUS_ACC) |=> acc_q == 8'($past(ex_k_q) - $past(acc_q))
		&& c_q == ($past(ex_k_q) >= $past(acc_q)))
		else $error("literal minus accumulator wrong");
	chk_reg_minus_acc_file: assert property (@(posedge CLK) disable iff (RST)
		s_exec(ies_pkg::OP_REG_MINUS_ACC) && ex_dst_q == ies_pkg::DEST_FILE
		|=> fmem[$past(ex_f_q)] == $past(alu_res) && $stable(acc_q) && z_q == (fmem[$past(ex_f_q)] == 8'h00))
		else $error("register minus accumulator not stored back");
	chk_swap_flags: assert property (@(posedge CLK) disable iff (RST)
		s_exec(ies_pkg::OP_NIBBLE_EXCHANGE) |-> alu_res == {fmem[ex_f_q][3:0], fmem[ex_f_q][7:4]}
		##1 $stable({c_q, dc_q, z_q}))
		else $error("nibble exchange wrong or flags moved");
	chk_xor_zero: assert property (@(posedge CLK) disable iff (RST)
		(s_exec(ies_pkg::OP_XOR_ACC_REG) or s_exec(ies_pkg::OP_XOR_ACC_LITERAL))
		|=> z_q == ($past(alu_res) == 8'h00) && $stable({c_q, dc_q}))
		else $error("xor touched carry or zero wrong");
endmodule

// ### ies_pkg.sv
package ies_pkg;
	// register byte offsets
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_ACC  = 5'h04;
	localparam logic [4:0] OFF_STAT = 5'h08;
	localparam logic [4:0] OFF_FADR = 5'h0c;
	localparam logic [4:0] OFF_FDAT = 5'h10;
	localparam logic [4:0] OFF_PC   = 5'h14;
	localparam logic [4:0] OFF_PUSH = 5'h18;
	localparam logic [4:0] OFF_WDT  = 5'h1c;
	// control word fields
	localparam int CTRL_OP_LSB   = 0;
	localparam int CTRL_DST_BIT  = 4;
	localparam int CTRL_F_LSB    = 8;
	localparam int CTRL_K_LSB    = 16;
	localparam int CTRL_WAKE_BIT = 31;
	// status bit positions
	localparam int SB_C    = 0;
	localparam int SB_DC   = 1;
	localparam int SB_Z    = 2;
	localparam int SB_PD   = 3;
	localparam int SB_TO   = 4;
	localparam int SB_SLP  = 5;
	localparam int SB_BUSY = 6;
	// operation codes
	localparam logic [3:0] OP_NOP    = 4'h0;
	localparam logic [3:0] OP_SLEEP  = 4'h1;
	localparam logic [3:0] OP_RETURN = 4'h2;
	localparam logic [3:0] OP_RRF    = 4'h3;
	localparam logic [3:0] OP_LITERAL_MINUS_ACC  = 4'h4;
	localparam logic [3:0] OP_REG_MINUS_ACC  = 4'h5;
	localparam logic [3:0] OP_NIBBLE_EXCHANGE  = 4'h6;
	localparam logic [3:0] OP_XOR_ACC_REG  = 4'h7;
	localparam logic [3:0] OP_XOR_ACC_LITERAL  = 4'h8;
	localparam logic       DEST_ACC  = 1'b0;
	localparam logic       DEST_FILE = 1'b1;
	// reset and clear values
	localparam logic [7:0]  ACC_RST  = 8'h00;
	localparam logic [7:0]  WDT_CLR  = 8'h00;
	localparam logic [12:0] PC_RST   = 13'h0000;
	localparam logic        TO_RST   = 1'b1;
	localparam logic        PD_RST   = 1'b1;
	localparam logic [1:0]  RESP_OK  = 2'b00;
	localparam logic [1:0]  RESP_ERR = 2'b10;
	typedef enum logic [1:0] {IES_RUN, IES_RET, IES_SLEEP} ies_state_e;
endpackage

// ### ies_alu.sv
`timescale 1ns/1ps
module ies_alu (
	// operation and operands
	input  wire logic [3:0] op,
	input  wire logic [7:0] acc,
	input  wire logic [7:0] freg,
	input  wire logic [7:0] lit,
	input  wire logic       c_in,
	// result and flag updates
	output logic [7:0] res,
	output logic       c_out,
	output logic       dc_out,
	output logic       z_out,
	output logic       wr_c,
	output logic       wr_dc,
	output logic       wr_z
);
	// {carry, digit carry, difference}; carry high means no borrow
	function automatic logic [9:0] sub_flags(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] full;
		logic [4:0] lo;
		full = {1'b0, a} + {1'b0, ~b} + 9'h001;
		lo = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
		return {full[8], lo[4], full[7:0]};
	endfunction

	logic [9:0] sub_r;

	always_comb begin
		sub_r = 10'h000;
		res = freg;
		c_out = c_in;
		dc_out = 1'b0;
		wr_c = 1'b0;
		wr_dc = 1'b0;
		wr_z = 1'b0;
		case (op)
			ies_pkg::OP_RRF: begin
				res = {c_in, freg[7:1]};
				c_out = freg[0];
				wr_c = 1'b1;
			end
			ies_pkg::OP_LITERAL_MINUS_ACC: begin
				sub_r = sub_flags(lit, acc);
				res = sub_r[7:0];
				c_out = sub_r[9];
				dc_out = sub_r[8];
				wr_c = 1'b1;
				wr_dc = 1'b1;
				wr_z = 1'b1;
			end
			ies_pkg::OP_REG_MINUS_ACC: begin
				sub_r = sub_flags(freg, acc);
				res = sub_r[7:0];
				c_out = sub_r[9];
				dc_out = sub_r[8];
				wr_c = 1'b1;
				wr_dc = 1'b1;
				wr_z = 1'b1;
			end
			ies_pkg::OP_NIBBLE_EXCHANGE: begin
				res = {freg[3:0], freg[7:4]};
			end
			ies_pkg::OP_XOR_ACC_REG: begin
				res = acc ^ freg;
				wr_z = 1'b1;
			end
			ies_pkg::OP_XOR_ACC_LITERAL: begin
				res = acc ^ lit;
				wr_z = 1'b1;
			end
			default: begin
				res = freg;
			end
		endcase
		z_out = (res == 8'h00);
	end
endmodule

// ### tb_core_instruction_exec_subset.sv
`timescale 1ns/1ps
module tb_core_instruction_exec_subset;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  aw_a = '0;
	logic        aw_v = 1'b0;
	logic        aw_r;
	logic [31:0] w_d = '0;
	logic        w_v = 1'b0;
	logic        w_r;
	logic [1:0]  b_resp;
	logic        b_v;
	logic        b_r = 1'b0;
	logic [4:0]  ar_a = '0;
	logic        ar_v = 1'b0;
	logic        ar_r;
	logic [31:0] r_d;
	logic [1:0]  r_resp;
	logic        r_v;
	logic        r_r = 1'b0;
	logic        osc_run;
	logic        sleeping;
	int          n_errors = 0;
	int          check_count = 0;

	always #20 clk = ~clk;

	// short prescaler so the watchdog overflows within the run
	ies_core #(.PRESC_W(2)) u_dut (
		.CLK(clk), .RST(rst),
		.S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_r),
		.S_AXI_WDATA(w_d), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_r),
		.S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r),
		.S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_r),
		.S_AXI_RDATA(r_d), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r),
		.OSC_RUN(osc_run), .SLEEPING(sleeping)
	);

	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic hang();
		n_errors++;
		$display("MISMATCH t=%0t wait ran out", $time);
		end_of_test();
	endtask

	// handshakes judged on the rising edge itself, released right after it
	task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		aw_a <= a;
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(posedge clk);
			if (aw_v && aw_r) aw_v <= 1'b0;
			if (w_v && w_r) w_v <= 1'b0;
			if (b_v && b_r) begin
				r = b_resp;
				b_r <= 1'b0;
				return;
			end
		end
		hang();
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(posedge clk);
			if (ar_v && ar_r) ar_v <= 1'b0;
			if (r_v && r_r) begin
				d = r_d;
				r_r <= 1'b0;
				return;
			end
		end
		hang();
	endtask

	task automatic put(input logic [4:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
	endtask

	task automatic rchk(input logic [4:0] a, input logic [31:0] exp, input logic [31:0] m);
		logic [31:0] d;
		rd(a, d);
		check(d & m, exp);
	endtask

	task automatic setf(input logic [6:0] f, input logic [7:0] v);
		put(ies_pkg::OFF_FADR, {25'h0, f});
		put(ies_pkg::OFF_FDAT, {24'h0, v});
	endtask

	task automatic setup(input logic [7:0] acc, input logic [2:0] st);
		put(ies_pkg::OFF_ACC, {24'h0, acc});
		put(ies_pkg::OFF_STAT, {29'h0, st});
	endtask

	task automatic exec(input logic [3:0] op, input logic dst, input logic [6:0] f,
		input logic [7:0] k);
		logic [31:0] s;
		put(ies_pkg::OFF_CTRL, {8'h00, k, 1'b0, f, 3'h0, dst, op});
		for (int i = 0; i < 20; i++) begin
			rd(ies_pkg::OFF_STAT, s);
			if (s[ies_pkg::SB_BUSY] === 1'b0) return;
		end
		hang();
	endtask

	// result lands in the target; for a file target the accumulator keeps its value
	task automatic dchk(input logic dst, input logic [6:0] f, input logic [7:0] res,
		input logic [7:0] acc0);
		if (dst) begin
			put(ies_pkg::OFF_FADR, {25'h0, f});
			rchk(ies_pkg::OFF_FDAT, {24'h0, res}, 32'hff);
			rchk(ies_pkg::OFF_ACC, {24'h0, acc0}, 32'hff);
		end else begin
			rchk(ies_pkg::OFF_ACC, {24'h0, res}, 32'hff);
		end
	endtask

	task automatic t_sub();
		logic [7:0] kk [4] = '{8'h05, 8'h10, 8'h01, 8'hff};
		logic [7:0] ww [4] = '{8'h05, 8'h01, 8'h02, 8'h00};
		logic [7:0] k, w, res;
		logic [2:0] fl;
		for (int i = 0; i < 8; i++) begin
			k = kk[i % 4];
			w = ww[i % 4];
			res = k - w;
			fl = {res == 8'h00, k[3:0] >= w[3:0], k >= w};
			// flags preset inverted so a missed update shows
			setup(w, ~fl);
			if (i < 4) begin
				exec(ies_pkg::OP_LITERAL_MINUS_ACC, 1'b0, 7'h00, k);
				dchk(1'b0, 7'h00, res, w);
				rchk(ies_pkg::OFF_STAT, {29'h0, fl}, 32'h7);
			end else begin
				setf(7'h40, k);
				exec(ies_pkg::OP_REG_MINUS_ACC, i[0], 7'h40, 8'h00);
				dchk(i[0], 7'h40, res, w);
				rchk(ies_pkg::OFF_STAT, {29'h0, fl}, 32'h7);
			end
		end
	endtask

	task automatic t_rrf();
		logic [7:0] v, res;
		for (int i = 0; i < 4; i++) begin
			v = i[1] ? 8'h7e : 8'h81;
			res = {i[0], v[7:1]};
			setup(8'h33, {2'b11, i[0]});
			setf(7'h7f, v);
			exec(ies_pkg::OP_RRF, i[1], 7'h7f, 8'h00);
			dchk(i[1], 7'h7f, res, 8'h33);
			rchk(ies_pkg::OFF_STAT, {29'h0, 2'b11, v[0]}, 32'h7);
		end
	endtask

	task automatic t_swap();
		for (int i = 0; i < 2; i++) begin
			setup(8'h00, i[0] ? 3'b101 : 3'b010);
			setf(7'h00, 8'ha5);
			exec(ies_pkg::OP_NIBBLE_EXCHANGE, i[0], 7'h00, 8'h00);
			dchk(i[0], 7'h00, 8'h5a, 8'h00);
			rchk(ies_pkg::OFF_STAT, i[0] ? 32'h5 : 32'h2, 32'h7);
		end
	endtask

	task automatic t_xor();
		logic [7:0] v, res;
		for (int i = 0; i < 6; i++) begin
			v = i[1] ? 8'h0f : 8'h3c;
			res = 8'h3c ^ v;
			if (i < 4) begin
				setup(8'h3c, {res != 8'h00, 2'b11});
				setf(7'h11, v);
				exec(ies_pkg::OP_XOR_ACC_REG, i[0], 7'h11, 8'h00);
				dchk(i[0], 7'h11, res, 8'h3c);
				rchk(ies_pkg::OFF_STAT, {29'h0, res == 8'h00, 2'b11}, 32'h7);
			end else begin
				setup(8'h3c, {res != 8'h00, 2'b00});
				exec(ies_pkg::OP_XOR_ACC_LITERAL, 1'b1, 7'h11, v);
				dchk(1'b0, 7'h11, res, 8'h3c);
				rchk(ies_pkg::OFF_STAT, {29'h0, res == 8'h00, 2'b00}, 32'h7);
			end
		end
	endtask

	task automatic t_ret();
		setup(8'h00, 3'b101);
		put(ies_pkg::OFF_PUSH, 32'h1234);
		put(ies_pkg::OFF_PUSH, 32'h0456);
		exec(ies_pkg::OP_RETURN, 1'b0, 7'h00, 8'h00);
		rchk(ies_pkg::OFF_PC, 32'h0456, 32'hffffffff);
		rchk(ies_pkg::OFF_PUSH, 32'h1, 32'hffffffff);
		exec(ies_pkg::OP_RETURN, 1'b0, 7'h00, 8'h00);
		rchk(ies_pkg::OFF_PC, 32'h1234, 32'hffffffff);
		rchk(ies_pkg::OFF_PUSH, 32'h0, 32'hffffffff);
		rchk(ies_pkg::OFF_STAT, 32'h5, 32'h7);
	endtask

	task automatic t_sleep();
		logic [31:0] s;
		logic [1:0]  r;
		int          n;
		// expiry flag must first be cleared by a watchdog overflow
		for (n = 0; n < 600; n++) begin
			rd(ies_pkg::OFF_STAT, s);
			if (s[ies_pkg::SB_TO] === 1'b0) break;
		end
		if (n == 600) hang();
		for (n = 0; n < 200; n++) begin
			rd(ies_pkg::OFF_WDT, s);
			if (s[7:0] >= 8'h40) break;
		end
		if (n == 200) hang();
		exec(ies_pkg::OP_SLEEP, 1'b0, 7'h00, 8'h00);
		rd(ies_pkg::OFF_WDT, s);
		check(s < 32'h8, 32'h1);
		rchk(ies_pkg::OFF_STAT, 32'h30, 32'h38);
		check({osc_run, sleeping}, 32'h1);
		wr(ies_pkg::OFF_CTRL, 32'h0, r);
		check(r, ies_pkg::RESP_ERR);
		wr(ies_pkg::OFF_CTRL, 32'h80000000, r);
		rd(ies_pkg::OFF_STAT, s);
		check({osc_run, sleeping}, 32'h2);
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_sub();
		t_rrf();
		t_swap();
		t_xor();
		t_ret();
		t_sleep();
		end_of_test();
	end
endmodule
